/* dv/tdm_far_end.sv */
// Far-end framer model: bit clock, frame sync and data in both directions
`timescale 1ns/1ps
module tdm_far_end (
  output logic clk_o,
  output logic rxd_o,
  output logic fs_o,
  input wire logic txd_i,
  input wire logic txoe_i
);
  logic [31:0] txw;
  event fdone;

  initial begin
    clk_o = 1'b0;
    rxd_o = 1'b0;
    fs_o = 1'b0;
    txw = '0;
  end

  // One four-slot frame, first bit first; clock stands still between frames
  task automatic frame(input logic [31:0] w);
    // Start off the core clock's edges so a pin never moves on a sample
    #5;
    for (int i = 0; i < 33; i++) begin
      clk_o = 1'b0;
      // Released data line toggles so a stale bit is never mistaken for data
      rxd_o = (i < 32) ? w[31-i] : ~rxd_o;
      fs_o = (i == 0);
      #70;
      // Sample late in the bit, well clear of the port's sync latency
      if (i > 0) begin
        txw[32-i] = txoe_i ? txd_i : 1'bz;
      end
      #10;
      if (i < 32) begin
        clk_o = 1'b1;
        #80;
      end
    end
    ->fdone;
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the TDM serial port
`timescale 1ns/1ps
module testbench;
  logic CORE_CLK_I, RESETN_I, WR_I, RD_I, rd_d, tx_chk;
  logic [11:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic TXD_O, TXD_OE_O, lclk, lrxd, lfs;
  logic RXFS_O, RXFS_OE_O, TXFS_O, TXFS_OE_O;
  logic [31:0] expq[$];
  logic [31:0] rxw[5];
  logic [7:0] vb[8];
  logic [7:0] hb[4];
  logic [15:0] seed;
  int error_cnt, check_count;

  tdm_serial_port u_dut (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .RXCLK_I(lclk), .RXD_I(lrxd), .RXFS_I(lfs), .RXFS_O(RXFS_O),
    .RXFS_OE_O(RXFS_OE_O), .TXCLK_I(lclk), .TXD_O(TXD_O),
    .TXD_OE_O(TXD_OE_O), .TXFS_I(lfs), .TXFS_O(TXFS_O),
    .TXFS_OE_O(TXFS_OE_O)
  );

  tdm_far_end u_far (
    .clk_o(lclk), .rxd_o(lrxd), .fs_o(lfs), .txd_i(TXD_O),
    .txoe_i(TXD_OE_O)
  );

  initial begin
    CORE_CLK_I = 1'b0;
    forever #10 CORE_CLK_I = ~CORE_CLK_I;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge CORE_CLK_I) begin
    rd_d <= RD_I;
    if (rd_d === 1'b1) begin
      chk(RDATA_O, expq.pop_front());
    end
  end

  always @(u_far.fdone) begin
    if (tx_chk) begin
      chk(u_far.txw, expq.pop_front());
    end
  end

  // Filler and invalid-bit level step through zero, one, high impedance
  function automatic logic [31:0] txexp(input int f);
    logic [31:0] e;
    int m;
    m = f % 3;
    e = {vb[2*f], hb[f], 8'h00, vb[2*f+1]};
    if (m == 1) begin
      e[15:8] = 8'hff;
    end
    if (m == 2) begin
      e[15:8] = 8'hzz;
    end
    e[f[0] ? 7 : 0] = (m == 2) ? 1'bz : m[0];
    return e;
  endfunction

  function automatic logic [31:0] ctrl(input int f);
    return 32'h0001005f | (32'(f % 3) << 10) | (32'(f[0]) << 12) |
      (32'(f % 3) << 13);
  endfunction

  initial begin
    RESETN_I = 1'b0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 12'h000;
    WDATA_I = 32'h0;
    tx_chk = 1'b0;
    seed = 16'h989d;
    error_cnt = 0;
    check_count = 0;
    repeat (3) @(posedge CORE_CLK_I);
    RESETN_I <= 1'b1;
    rd(12'h000, 32'h00000002);
    rd(12'h004, 32'h000000ff);
    rd(12'h800, 32'h00000000);
    rd(12'h100, 32'h00000000);
    wr(12'h004, 32'h03ff03ff);
    rd(12'h004, 32'h03ff03ff);
    wr(12'h004, 32'h0000001f);
    wr(12'h100, 32'h000000c6);
    wr(12'h200, 32'h000000c6);
    for (int i = 0; i < 8; i++) begin
      vb[i] = rnd();
    end
    for (int i = 0; i < 4; i++) begin
      hb[i] = rnd();
    end
    wr(12'h040, {vb[3], vb[2], vb[1], vb[0]});
    wr(12'h044, {vb[7], vb[6], vb[5], vb[4]});
    wr(12'h034, {hb[3], hb[2], hb[1], hb[0]});
    tx_chk = 1'b1;
    // Fifth frame finds bank 0 drained and bank 1 never written: underrun expected
    for (int f = 0; f < 5; f++) begin
      rxw[f] = {rnd(), rnd(), rnd(), rnd()};
      if (f == 4) begin
        tx_chk = 1'b0;
      end else begin
        expq.push_back(txexp(f));
      end
      wr(12'h000, ctrl(f));
      repeat (4) @(posedge CORE_CLK_I);
      u_far.frame(rxw[f]);
      repeat (8) @(posedge CORE_CLK_I);
      if (f == 3) begin
        rd(12'h014, {rxw[3][23:16], rxw[2][23:16], rxw[1][23:16],
          rxw[0][23:16]});
        rd(12'h020, {rxw[1][7:0], rxw[1][31:24], rxw[0][7:0],
          rxw[0][31:24]});
        rd(12'h024, {rxw[3][7:0], rxw[3][31:24], rxw[2][7:0],
          rxw[2][31:24]});
      end
    end
    rd(12'h008, 32'h00000e40);
    wr(12'h008, 32'h000003ff);
    rd(12'h008, 32'h00000c00);
    repeat (4) @(posedge CORE_CLK_I);
    // Syncs are inputs here: never driven, idle level of active-high is 0
    chk({28'h0, RXFS_O, RXFS_OE_O, TXFS_O, TXFS_OE_O}, 32'h0);
    conclude();
  end

  // Whole run needs under 2000 core cycles; this is a generous ceiling
  initial begin
    repeat (20000) @(posedge CORE_CLK_I);
    error_cnt++;
    conclude();
  end
endmodule

/* rtl/pingpong_buf.sv */
// Two-bank ping-pong buffer: bytes on the link side, words on the engine side
`timescale 1ns/1ps
module pingpong_buf import tdm_pkg::*; #(
  parameter int BYTES = 4,
  parameter bit LINK_WR = 1'b1,
  parameter bit INIT_OWN = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic bstb_i,
  input wire logic [7:0] bdata_i,
  output logic [7:0] bdata_o,
  input wire logic wstb_i,
  input wire logic wwr_i,
  input wire logic widx_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] wdata_o,
  output logic err_o
);
  localparam logic [2:0] LAST_B = 3'(BYTES - 1);
  localparam logic LAST_W = 1'(BYTES / 4 - 1);
  pp_state_t r, n;

  // Link touching a bank the engine still holds is an overrun/underrun
  assign err_o = bstb_i & r.own[r.lb];
  assign bdata_o = r.mem[r.lb][{r.bcnt, 3'b000} +: 8];
  assign wdata_o = r.mem[r.eb][{widx_i, 5'b00000} +: 32];

  always_comb begin
    n = r;
    if (wstb_i) begin
      if (wwr_i) begin
        n.mem[r.eb][{widx_i, 5'b00000} +: 32] = wdata_i;
      end
      if (widx_i == LAST_W) begin
        n.own[r.eb] = 1'b0;
        n.eb = ~r.eb;
      end
    end
    if (bstb_i) begin
      if (LINK_WR) begin
        n.mem[r.lb][{r.bcnt, 3'b000} +: 8] = bdata_i;
      end
      // Hand-over after the engine clear, so the set wins
      if (r.bcnt == LAST_B) begin
        n.bcnt = 3'h0;
        n.lb = ~r.lb;
        n.own[r.lb] = 1'b1;
      end else begin
        n.bcnt = r.bcnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '{own: {2{INIT_OWN}}, default: '0};
    end else begin
      r <= n;
    end
  end
endmodule

/* rtl/slot_lut.sv */
// Slot type table: 2 bits per slot, registered read
`timescale 1ns/1ps
module slot_lut import tdm_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic we_i,
  input wire logic [2:0] widx_i,
  input wire logic [31:0] wdata_i,
  input wire logic [6:0] slot_i,
  output logic [1:0] type_o
);
  lut_state_t r, n;

  always_comb begin
    n = r;
    if (we_i) begin
      n.mem[widx_i] = wdata_i;
    end
    n.q = r.mem[slot_i[6:4]][{slot_i[3:0], 1'b0} +: 2];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign type_o = r.q;
endmodule

/* rtl/tdm_defines.svh */
// Register offsets, field positions and reset values of the TDM port
`ifndef TDM_DEFINES_SVH
`define TDM_DEFINES_SVH
`define ADDR_CTRL 12'h000
`define ADDR_FRAME 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_RXH 12'h010
`define ADDR_RXV 12'h020
`define ADDR_TXH 12'h030
`define ADDR_TXV 12'h040
`define ADDR_HMASK 12'hff0
`define ADDR_VMASK 12'hff8
`define LUT_RX_BLK 7'h08
`define LUT_TX_BLK 7'h10
`define C_EN 0
`define C_MSB 1
`define C_RXRISE 2
`define C_TXRISE 3
`define C_RXFSM 4
`define C_TXFSM 6
`define C_RXFSO 8
`define C_TXFSO 9
`define C_FILL 10
`define C_INVMSB 12
`define C_INVLVL 13
`define C_ARR 15
`define C_W 17
`define F_LEN 0
`define F_OFF 16
`define CTRL_RST 17'h00002
`define FLEN_RST 10'h0ff
`define OFF_RST 10'h000
`define STAT_W 10
`define PP_HDLC_BYTES 4
`define PP_VOICE_BYTES 8
`endif

/* rtl/tdm_pkg.sv */
// Types shared by the TDM serial port modules
package tdm_pkg;
  typedef enum logic [1:0] {
    SLOT_UNASSIGNED,
    SLOT_HDLC,
    SLOT_VOICE,
    SLOT_56K
  } slot_t;

  typedef struct packed {
    logic [7:0][31:0] mem;
    logic [1:0] q;
  } lut_state_t;

  typedef struct packed {
    logic [1:0][63:0] mem;
    logic [1:0] own;
    logic lb;
    logic eb;
    logic [2:0] bcnt;
  } pp_state_t;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] sy3;
    logic [1:0][9:0] fcnt;
    logic [1:0] sync;
    logic [1:0] fsprev;
    logic [1:0] fso;
    logic [1:0] fsoe;
    logic [7:0] rsh;
    logic [7:0] tbyte;
    logic txd;
    logic txoe;
    logic [16:0] ctrl;
    logic [9:0] flen;
    logic [9:0] off;
    logic [9:0] stat;
    logic [31:0] rdata;
  } top_state_t;
endpackage

/* rtl/tdm_serial_port.sv */
// TDM bit-serial port: framing, slot routing and register port
//
// Overview of operation
// R01 - Six-wire serial link, 512 KHz to 8.192 MHz
// R02 - Frame length, offset, polarity, bit order programmable
// R03 - Each eight bits form one slot, from zero
// R04 - Four receive HDLC FIFOs, two one-word buffers
// R05 - HDLC buffers swap between port and engine
// R06 - Voice FIFO, two two-word ping-pong buffers
// R07 - Receive table types slots four ways
// R08 - Voice slot byte goes to voice FIFO
// R09 - HDLC slot byte goes to chosen HDLC FIFO
// R10 - Unassigned slot byte is dropped
// R11 - 56-K slot byte goes to voice FIFO
// R12 - Transmit side mirrors FIFOs, own table
// R13 - Voice transmit slot drawn from voice FIFO
// R14 - HDLC transmit slot drawn from chosen FIFO
// R15 - Unassigned transmit slot sends programmable filler
// R16 - 56-K slot from voice, one invalid bit
// R17 - Invalid bit place and level programmable
// R18 - Frame length up to 1,024 bits
// R19 - Frame-sync offset 0 to 1,023 bits
// R20 - Frame syncs in or out, four modes
// R21 - Tables hold two-bit type per slot
// R22 - Overrun and underrun are reported
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "tdm_defines.svh"
module tdm_serial_port import tdm_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic RXCLK_I,
  input wire logic RXD_I,
  input wire logic RXFS_I,
  output logic RXFS_O,
  output logic RXFS_OE_O,
  input wire logic TXCLK_I,
  output logic TXD_O,
  output logic TXD_OE_O,
  input wire logic TXFS_I,
  output logic TXFS_O,
  output logic TXFS_OE_O
);
  localparam top_state_t ST_RST = '{ctrl: `CTRL_RST, flen: `FLEN_RST,
                                    off: `OFF_RST, default: '0};
  top_state_t r, n;
  logic en, msb, inv_msb;
  logic [1:0] fill, lvl, arr, mask, rch, tch, rq, tq;
  logic [1:0][1:0] fsm;
  logic [1:0] fsout, crise, step, hit, synced;
  logic [1:0][9:0] pos;
  logic [10:0] len;
  logic [9:0] start;
  logic rise, fall, fse, gen, fsin;
  int ci;
  logic rx_done, tval, toe, lwe_rx, lwe_tx;
  logic [7:0] rbyte, tcur;
  logic [2:0] tsrc, bi;
  logic [31:0] rval;
  logic [4:0] rx_bstb, tx_bstb, rx_wstb, tx_wstb, rx_err, tx_err;
  logic [4:0] rx_widx, tx_widx;
  logic [4:0][7:0] tx_bdata;
  logic [4:0][31:0] rx_wdata;

  // R02
  assign en = r.ctrl[`C_EN];
  assign msb = r.ctrl[`C_MSB];
  assign inv_msb = r.ctrl[`C_INVMSB];
  assign fill = r.ctrl[`C_FILL +: 2];
  assign lvl = r.ctrl[`C_INVLVL +: 2];
  assign arr = r.ctrl[`C_ARR +: 2];
  assign fsm[0] = r.ctrl[`C_RXFSM +: 2];
  assign fsm[1] = r.ctrl[`C_TXFSM +: 2];
  assign fsout = {r.ctrl[`C_TXFSO], r.ctrl[`C_RXFSO]};
  assign crise = {r.ctrl[`C_TXRISE], r.ctrl[`C_RXRISE]};
  // HDLC arrangement: one, two or four channels by slot number
  assign mask = (arr == 2'h0) ? 2'h0 : ((arr == 2'h1) ? 2'h1 : 2'h3);
  assign rch = pos[0][4:3] & mask; // R09
  assign tch = pos[1][4:3] & mask; // R14

  // Detection is the change into the active level in every mode
  function automatic logic fs_act(input logic [1:0] m, input logic now,
                                  input logic prev);
    return (now == m[0]) && (prev != m[0]);
  endfunction

  always_comb begin
    n = r;
    step = 2'b00;
    hit = 2'b00;
    synced = 2'b00;
    pos = r.fcnt;
    rise = 1'b0;
    fall = 1'b0;
    fse = 1'b0;
    gen = 1'b0;
    fsin = 1'b0;
    ci = 0;
    rx_done = 1'b0;
    rbyte = r.rsh;
    rx_bstb = 5'h00;
    tx_bstb = 5'h00;
    tsrc = 3'h4;
    tcur = r.tbyte;
    bi = 3'h0;
    tval = 1'b0;
    toe = 1'b0;
    rval = 32'h0;
    rx_wstb = 5'h00;
    tx_wstb = 5'h00;
    rx_widx = 5'h00;
    tx_widx = 5'h00;
    // Link pins are asynchronous; edges are found on the second stage
    n.sy1 = {RXD_I, RXFS_I, RXCLK_I, TXFS_I, TXCLK_I}; // R01
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    len = {1'b0, r.flen} + 11'h001;
    start = (r.off == 10'h000) ? 10'h000 : 10'(len - {1'b0, r.off}); // R19
    // Index 0 is receive, 1 is transmit
    for (int d = 0; d < 2; d++) begin
      ci = (d == 0) ? 2 : 0;
      rise = r.sy2[ci] & ~r.sy3[ci];
      fall = ~r.sy2[ci] & r.sy3[ci];
      step[d] = en & (crise[d] ? rise : fall);
      fse = en & (fsm[d][1] ? (fsm[d][0] ? rise : fall) : step[d]); // R20
      fsin = r.sy2[ci + 1];
      gen = r.fcnt[d] == start;
      hit[d] = fse & (fsout[d] ? gen : fs_act(fsm[d], fsin, r.fsprev[d]));
      if (fse) begin
        n.fsprev[d] = fsin;
        n.fso[d] = gen ? fsm[d][0] : ~fsm[d][0]; // R20
      end
      n.fsoe[d] = en & fsout[d]; // R20
      if (hit[d] && !fsout[d]) begin
        pos[d] = start; // R19
      end
      synced[d] = en & (fsout[d] | r.sync[d] | hit[d]);
      if (!en) begin
        n.sync[d] = 1'b0;
        n.fcnt[d] = 10'h000;
        n.fso[d] = ~fsm[d][0];
      end else begin
        n.sync[d] = synced[d];
        if (step[d] && synced[d]) begin
          n.fcnt[d] = (pos[d] == r.flen) ? 10'h000 : pos[d] + 10'h001; // R18
        end else if (hit[d]) begin
          n.fcnt[d] = pos[d];
        end
      end
    end

    // Receive: shift a bit in, route the byte at slot end
    if (step[0] && synced[0]) begin
      rbyte = msb ? {r.rsh[6:0], r.sy2[4]} : {r.sy2[4], r.rsh[7:1]}; // R02
      n.rsh = rbyte;
      rx_done = pos[0][2:0] == 3'h7; // R03
    end
    if (rx_done) begin
      case (rq)
        SLOT_HDLC: rx_bstb[rch] = 1'b1; // R09
        SLOT_VOICE: rx_bstb[4] = 1'b1; // R08
        SLOT_56K: rx_bstb[4] = 1'b1; // R11
        default: rx_bstb = 5'h00; // R10
      endcase
    end

    // Transmit: fetch at bit 0 of a slot, set TXD and its output enable every bit
    if (step[1] && synced[1]) begin
      tsrc = (tq == SLOT_HDLC) ? {1'b0, tch} : 3'h4; // R13 R14 R16
      if (pos[1][2:0] == 3'h0) begin
        tcur = tx_bdata[tsrc];
        if (tq != SLOT_UNASSIGNED) begin
          tx_bstb[tsrc] = 1'b1;
          n.tbyte = tcur;
        end
      end
      bi = msb ? 3'h7 - pos[1][2:0] : pos[1][2:0];
      tval = tcur[bi];
      toe = 1'b1;
      if (tq == SLOT_UNASSIGNED) begin
        tval = fill[0]; // R15
        toe = ~fill[1];
      end else if (tq == SLOT_56K && bi == (inv_msb ? 3'h7 : 3'h0)) begin
        tval = lvl[0]; // R17
        toe = ~lvl[1];
      end
      n.txd = tval;
      n.txoe = toe;
    end else if (!synced[1]) begin
      n.txoe = 1'b0;
    end

    // Register port
    for (int k = 0; k < 4; k++) begin
      rx_wstb[k] = RD_I && (ADDR_I == 12'(`ADDR_RXH + 4 * k));
      tx_wstb[k] = WR_I && (ADDR_I == 12'(`ADDR_TXH + 4 * k));
    end
    rx_wstb[4] = RD_I && ((ADDR_I & `ADDR_VMASK) == `ADDR_RXV); // R06
    tx_wstb[4] = WR_I && ((ADDR_I & `ADDR_VMASK) == `ADDR_TXV);
    rx_widx[4] = ADDR_I[2];
    tx_widx[4] = ADDR_I[2];
    if (WR_I) begin
      if (ADDR_I == `ADDR_CTRL) begin
        n.ctrl = WDATA_I[`C_W - 1:0]; // R02
      end else if (ADDR_I == `ADDR_FRAME) begin
        n.flen = WDATA_I[`F_LEN +: 10]; // R18
        n.off = WDATA_I[`F_OFF +: 10]; // R19
      end else if (ADDR_I == `ADDR_STATUS) begin
        n.stat = r.stat & ~WDATA_I[`STAT_W - 1:0];
      end
    end
    // New events win over a write-one clear in the same cycle
    n.stat = n.stat | {tx_err, rx_err}; // R22
    if (ADDR_I == `ADDR_STATUS) begin
      rval = {20'h0, r.sync, r.stat};
    end else if (ADDR_I == `ADDR_CTRL) begin
      rval = {15'h0, r.ctrl};
    end else if (ADDR_I == `ADDR_FRAME) begin
      rval = {6'h0, r.off, 6'h0, r.flen};
    end else if ((ADDR_I & `ADDR_HMASK) == `ADDR_RXH) begin
      rval = rx_wdata[ADDR_I[3:2]];
    end else if ((ADDR_I & `ADDR_VMASK) == `ADDR_RXV) begin
      rval = rx_wdata[4];
    end
    n.rdata = RD_I ? rval : 32'h0;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign RDATA_O = r.rdata;
  assign TXD_O = r.txd;
  assign TXD_OE_O = r.txoe;
  assign RXFS_O = r.fso[0];
  assign RXFS_OE_O = r.fsoe[0];
  assign TXFS_O = r.fso[1];
  assign TXFS_OE_O = r.fsoe[1];

  // Tables are written with the port disabled; no read-back
  assign lwe_rx = WR_I && (ADDR_I[11:5] == `LUT_RX_BLK);
  assign lwe_tx = WR_I && (ADDR_I[11:5] == `LUT_TX_BLK);

  slot_lut u_rx_lut ( // R07 R21
    .core_clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .we_i(lwe_rx),
    .widx_i(ADDR_I[4:2]),
    .wdata_i(WDATA_I),
    .slot_i(r.fcnt[0][9:3]),
    .type_o(rq)
  );

  slot_lut u_tx_lut ( // R12 R21
    .core_clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .we_i(lwe_tx),
    .widx_i(ADDR_I[4:2]),
    .wdata_i(WDATA_I),
    .slot_i(r.fcnt[1][9:3]),
    .type_o(tq)
  );

  // FIFOs 0..3 are HDLC (one word per bank), 4 is voice (two words)
  for (genvar k = 0; k < 5; k++) begin : g_fifo
    pingpong_buf #( // R04 R05 R06
      .BYTES(k == 4 ? `PP_VOICE_BYTES : `PP_HDLC_BYTES),
      .LINK_WR(1'b1),
      .INIT_OWN(1'b0)
    ) u_rx (
      .core_clk_i(CORE_CLK_I),
      .resetn_i(RESETN_I),
      .bstb_i(rx_bstb[k]),
      .bdata_i(rbyte),
      .bdata_o(),
      .wstb_i(rx_wstb[k]),
      .wwr_i(1'b0),
      .widx_i(rx_widx[k]),
      .wdata_i(32'h0),
      .wdata_o(rx_wdata[k]),
      .err_o(rx_err[k])
    );
    pingpong_buf #( // R12
      .BYTES(k == 4 ? `PP_VOICE_BYTES : `PP_HDLC_BYTES),
      .LINK_WR(1'b0),
      .INIT_OWN(1'b1)
    ) u_tx (
      .core_clk_i(CORE_CLK_I),
      .resetn_i(RESETN_I),
      .bstb_i(tx_bstb[k]),
      .bdata_i(8'h00),
      .bdata_o(tx_bdata[k]),
      .wstb_i(tx_wstb[k]),
      .wwr_i(1'b1),
      .widx_i(tx_widx[k]),
      .wdata_i(WDATA_I),
      .wdata_o(),
      .err_o(tx_err[k])
    );
  end

  status_read_a: assert property (@(posedge CORE_CLK_I) // R22
    disable iff (!RESETN_I) RD_I && ADDR_I == `ADDR_STATUS |=>
    RDATA_O == {20'h0, $past(r.sync), $past(r.stat)})
    else $error("status read data wrong");
  rx_drop_a: assert property (@(posedge CORE_CLK_I) // R10
    disable iff (!RESETN_I) rx_done && rq == SLOT_UNASSIGNED |->
    rx_bstb == 5'h00) else $error("unassigned byte stored");
  rx_voice_a: assert property (@(posedge CORE_CLK_I) // R08
    disable iff (!RESETN_I) rx_done && rq == SLOT_VOICE |->
    rx_bstb == 5'h10) else $error("voice byte misrouted");
  rx_56k_a: assert property (@(posedge CORE_CLK_I) // R11
    disable iff (!RESETN_I) rx_done && rq == SLOT_56K |->
    rx_bstb == 5'h10) else $error("56-K byte misrouted");
  rx_hdlc_a: assert property (@(posedge CORE_CLK_I) // R09
    disable iff (!RESETN_I) rx_done && rq == SLOT_HDLC |->
    !rx_bstb[4] && $onehot(rx_bstb)) else $error("HDLC byte misrouted");
  tx_fill_a: assert property (@(posedge CORE_CLK_I) // R15
    disable iff (!RESETN_I) step[1] && synced[1] && tq == SLOT_UNASSIGNED
    |=> TXD_OE_O != $past(fill[1]) && (TXD_O == $past(fill[0])))
    else $error("filler bit wrong");
  tx_inv_bit_a: assert property (@(posedge CORE_CLK_I) // R17
    disable iff (!RESETN_I) step[1] && synced[1] && tq == SLOT_56K &&
    bi == (inv_msb ? 3'h7 : 3'h0) |=> TXD_OE_O != $past(lvl[1]) &&
    (TXD_O == $past(lvl[0]))) else $error("invalid bit level wrong");
  frame_wrap_a: assert property (@(posedge CORE_CLK_I) // R18
    disable iff (!RESETN_I) step[0] && synced[0] && pos[0] == r.flen
    |=> r.fcnt[0] == 10'h000) else $error("frame did not wrap");
  fs_offset_a: assert property (@(posedge CORE_CLK_I) // R19
    disable iff (!RESETN_I) hit[0] && !fsout[0] && start != r.flen |=>
    r.fcnt[0] == 10'($past(start) + 10'($past(step[0]))))
    else $error("offset not loaded");
endmodule
